//--- logic/spw_pkg.sv
package spw_pkg;
    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int CLK_NS = 100;
    localparam int MS_NS = 1000000;
    localparam int CYC_PER_MS_DEF = MS_NS / CLK_NS;
    localparam int MS_CNT_W = 16;

    // ---------------------------------------------------------------
    // Widths and counts
    // ---------------------------------------------------------------
    localparam int N_INST = 3;
    localparam int N_SDO = 4;
    localparam int POS_W = 32;
    localparam int DLY_W = 16;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int BYTE_W = 8;
    localparam int STRB_W = DATA_W / BYTE_W;

    // ---------------------------------------------------------------
    // Register map (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_LIM_CFG = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_LIM_UL = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_LIM_LL = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_LIM_DLY = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_CAM_CFG = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_CAM_UL = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_CAM_LL = 8'h18;
    localparam int INST_LSB = 5;
    localparam int INST_W = 2;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h60;
    localparam logic [ADDR_W-1:0] OFS_IRQ_ST = 8'h64;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MSK = 8'h68;
    localparam logic [ADDR_W-1:0] OFS_SDO_MAP = 8'h6c;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ---------------------------------------------------------------
    // Encodings
    // ---------------------------------------------------------------
    localparam logic [1:0] SRC_NEVER = 2'h0;
    localparam logic [1:0] SRC_FIELDBUS = 2'h1;
    localparam logic [1:0] SRC_SAFE_INPUT = 2'h2;
    localparam logic [1:0] REACT_NONE = 2'h0;
    localparam logic [1:0] REACT_TOF = 2'h1;
    localparam logic [1:0] REACT_SP1 = 2'h2;
    localparam logic [1:0] REACT_SP2 = 2'h3;
    localparam logic [1:0] ST_INACTIVE = 2'h0;
    localparam logic [1:0] ST_ACTIVE = 2'h1;
    localparam logic [1:0] ST_FAILED = 2'h2;
    localparam logic [1:0] CAM_ST_OFF = 2'h0;
    localparam logic [1:0] CAM_ST_IN = 2'h1;
    localparam logic [1:0] CAM_ST_OUT = 2'h2;
    localparam logic [2:0] MAP_NONE = 3'h0;
    localparam logic [2:0] MAP_LIM0 = 3'h1;
    localparam logic [2:0] MAP_CAM0 = 3'h4;

    // ---------------------------------------------------------------
    // Carriers
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [1:0] react;
        logic [1:0] in_sel;
        logic [1:0] src;
    } spw_limc_t;

    typedef struct packed {
        spw_limc_t limc;
        logic cam_en;
        logic [POS_W-1:0] lim_ul;
        logic [POS_W-1:0] lim_ll;
        logic [DLY_W-1:0] delay;
        logic [POS_W-1:0] cam_ul;
        logic [POS_W-1:0] cam_ll;
    } spw_icfg_t;

    typedef struct packed {
        logic lim_active;
        logic [1:0] lim_state;
        logic fault;
        logic [1:0] react;
        logic cam_in;
        logic [1:0] cam_state;
    } spw_ist_t;

    typedef struct packed {
        logic [1:0] pair;
        logic [N_SDO-1:0][2:0] sel;
    } spw_sdom_t;

    localparam int LIMC_W = $bits(spw_limc_t);
    localparam int SDOM_W = $bits(spw_sdom_t);
    localparam int IST_W = $bits(spw_ist_t);

    localparam spw_icfg_t ICFG_RST = '{
        limc: '{react: REACT_TOF, in_sel: 2'h0, src: SRC_NEVER},
        cam_en: 1'b0,
        lim_ul: 32'h0000_0001,
        lim_ll: 32'h0000_0001,
        delay: 16'h0000,
        cam_ul: 32'h0000_0000,
        cam_ll: 32'h0000_0000
    };
endpackage

//--- logic/spw_inst.sv
`timescale 1ns/1ns
module spw_inst (
    input wire logic aclk, // Clock
    input wire logic aresetn, // Sync reset
    input wire logic [spw_pkg::POS_W-1:0] position, // Safe position
    input wire logic activate, // Selected activation level
    input wire logic ms_tick, // One pulse per ms
    input wire spw_pkg::spw_icfg_t cfg, // Instance settings
    output spw_pkg::spw_ist_t st // Registered outputs
);
    import spw_pkg::*;

    typedef enum logic [1:0] {S_IDLE, S_DELAY, S_MON, S_FAIL} spw_ph_t;
    typedef struct packed {
        spw_ph_t ph;
        logic act_d;
        logic [DLY_W-1:0] cnt;
        spw_ist_t o;
    } spw_istate_t;

    spw_istate_t s_r;
    spw_istate_t s_nxt;
    logic lim_in;
    logic cam_in;

    always_comb begin
        // Limits are inclusive
        lim_in = ($signed(position) <= $signed(cfg.lim_ul)) && ($signed(position) >= $signed(cfg.lim_ll));
        cam_in = ($signed(position) <= $signed(cfg.cam_ul)) && ($signed(position) >= $signed(cfg.cam_ll));
        s_nxt = s_r;
        s_nxt.act_d = activate;
        case (s_r.ph)
            S_IDLE: begin
                if (activate && !s_r.act_d) begin
                    s_nxt.cnt = '0;
                    s_nxt.ph = (cfg.delay == '0) ? S_MON : S_DELAY;
                end
            end
            S_DELAY: begin
                // Free-running ms tick: wait one extra tick so the delay is never short
                if (!activate) begin
                    s_nxt.ph = S_IDLE;
                end else if (ms_tick) begin
                    s_nxt.cnt = s_r.cnt + 1'b1;
                    if (s_r.cnt == cfg.delay) begin
                        s_nxt.ph = S_MON;
                    end
                end
            end
            S_MON: begin
                if (!activate) begin
                    s_nxt.ph = S_IDLE;
                end else if (!lim_in) begin
                    s_nxt.ph = S_FAIL;
                end
            end
            S_FAIL: begin
                // Latched until the activation is withdrawn
                if (!activate) begin
                    s_nxt.ph = S_IDLE;
                end
            end
            default: begin
                s_nxt.ph = S_IDLE;
            end
        endcase
        s_nxt.o.lim_active = (s_nxt.ph != S_IDLE);
        s_nxt.o.lim_state = (s_nxt.ph == S_IDLE) ? ST_INACTIVE :
                            (s_nxt.ph == S_FAIL) ? ST_FAILED : ST_ACTIVE;
        s_nxt.o.fault = (s_nxt.ph == S_FAIL);
        s_nxt.o.react = cfg.limc.react;
        s_nxt.o.cam_in = cfg.cam_en && cam_in;
        s_nxt.o.cam_state = !cfg.cam_en ? CAM_ST_OFF : (cam_in ? CAM_ST_IN : CAM_ST_OUT);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign st = s_r.o;
endmodule

//--- logic/spw_monitor.sv
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
// Function
// - Fault when position leaves active window
// - Optional monitoring delay, default zero ms
// - Three independent instances per axis
// - Activation from fieldbus or mapped input
// - Outputs active, internal state, fault request
// - Selectable reaction: torque off, stop1, stop2
// - Failed keeps active, internal state two
// - Statuses mappable to safe outputs, pairable
// - Cam always active once configured, no reaction
// - Cam limits default to zero
// - Cam drives in-window flag and state
module spw_monitor #(
    parameter int unsigned CYC_PER_MS = spw_pkg::CYC_PER_MS_DEF
) (
    input wire logic aclk, // Clock, 10 MHz
    input wire logic aresetn, // Sync reset
    input wire logic awvalid, // AXI write address
    output logic awready, // AXI write address
    input wire logic [spw_pkg::ADDR_W-1:0] awaddr, // AXI write address
    input wire logic wvalid, // AXI write data
    output logic wready, // AXI write data
    input wire logic [spw_pkg::DATA_W-1:0] wdata, // AXI write data
    input wire logic [spw_pkg::STRB_W-1:0] wstrb, // AXI byte enables
    output logic bvalid, // AXI write response
    input wire logic bready, // AXI write response
    output logic [1:0] bresp, // AXI write response
    input wire logic arvalid, // AXI read address
    output logic arready, // AXI read address
    input wire logic [spw_pkg::ADDR_W-1:0] araddr, // AXI read address
    output logic rvalid, // AXI read data
    input wire logic rready, // AXI read data
    output logic [spw_pkg::DATA_W-1:0] rdata, // AXI read data
    output logic [1:0] rresp, // AXI read response
    input wire logic [spw_pkg::POS_W-1:0] safe_position, // Safe feedback position
    input wire logic [spw_pkg::N_INST-1:0] fieldbus_activate, // Fieldbus activation
    input wire logic [3:0] safe_input, // Safe digital inputs
    output logic [spw_pkg::N_INST-1:0] position_limit_active_status, // Active
    output logic [2*spw_pkg::N_INST-1:0] position_limit_internal_state, // 2 bits each
    output logic fault_activate, // Any instance failed
    output logic [1:0] fault_reaction, // Most severe reaction
    output logic [spw_pkg::N_INST-1:0] cam_in_window_status, // Cam in window
    output logic [2*spw_pkg::N_INST-1:0] cam_internal_state, // 2 bits each
    output logic [spw_pkg::N_SDO-1:0] test_pulsed_safe_output, // Output levels
    output logic irq // Level interrupt
);
    import spw_pkg::*;

    localparam int N_EV = 2 * N_INST;

    typedef struct packed {
        logic aw_v;
        logic [ADDR_W-1:0] aw_a;
        logic w_v;
        logic [DATA_W-1:0] w_d;
        logic [STRB_W-1:0] w_s;
        logic b_v;
        logic [1:0] b_r;
        logic r_v;
        logic [DATA_W-1:0] r_d;
        logic [1:0] r_r;
        spw_icfg_t [N_INST-1:0] cfg;
        spw_sdom_t sdom;
        logic [N_EV-1:0] irq_st;
        logic [N_EV-1:0] irq_msk;
        logic [MS_CNT_W-1:0] ms_cnt;
        logic ms_tick;
        logic [N_SDO-1:0] sdo;
        logic [N_INST-1:0] fail_d;
        logic [N_INST-1:0] cam_d;
        logic fault_any;
        logic [1:0] react;
    } spw_top_t;

    spw_top_t s_r;
    spw_top_t s_nxt;
    spw_ist_t [N_INST-1:0] ist;
    logic [N_INST-1:0] act;

    function automatic logic [DATA_W-1:0] spw_merge(input logic [DATA_W-1:0] old,
                                                   input logic [DATA_W-1:0] d,
                                                   input logic [STRB_W-1:0] s);
        logic [DATA_W-1:0] m;
        m = old;
        for (int b = 0; b < STRB_W; b++) begin
            if (s[b]) begin
                m[b*BYTE_W +: BYTE_W] = d[b*BYTE_W +: BYTE_W];
            end
        end
        return m;
    endfunction

    // ---------------------------------------------------------------
    // Instances
    // ---------------------------------------------------------------
    for (genvar i = 0; i < N_INST; i++) begin : g_inst
        always_comb begin
            case (s_r.cfg[i].limc.src)
                SRC_FIELDBUS: act[i] = fieldbus_activate[i];
                SRC_SAFE_INPUT: act[i] = safe_input[s_r.cfg[i].limc.in_sel];
                default: act[i] = 1'b0;
            endcase
        end

        spw_inst u_inst (
            .aclk(aclk),
            .aresetn(aresetn),
            .position(safe_position),
            .activate(act[i]),
            .ms_tick(s_r.ms_tick),
            .cfg(s_r.cfg[i]),
            .st(ist[i])
        );

        assign position_limit_active_status[i] = ist[i].lim_active;
        assign position_limit_internal_state[2*i +: 2] = ist[i].lim_state;
        assign cam_in_window_status[i] = ist[i].cam_in;
        assign cam_internal_state[2*i +: 2] = ist[i].cam_state;
    end

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        logic [INST_W-1:0] idx;
        logic [ADDR_W-1:0] off;
        logic [DATA_W-1:0] old;
        logic [DATA_W-1:0] m;
        logic hit;
        logic [N_EV-1:0] ev;
        logic [2:0] src;
        logic v;
        idx = '0;
        off = '0;
        old = '0;
        m = '0;
        hit = 1'b0;
        ev = '0;
        src = MAP_NONE;
        v = 1'b0;
        s_nxt = s_r;

        // ms prescaler, shared by all delay counters
        s_nxt.ms_tick = 1'b0;
        if (s_r.ms_cnt == MS_CNT_W'(CYC_PER_MS - 1)) begin
            s_nxt.ms_cnt = '0;
            s_nxt.ms_tick = 1'b1;
        end else begin
            s_nxt.ms_cnt = s_r.ms_cnt + 1'b1;
        end

        // Write channels, taken in either order
        if (awvalid && awready) begin
            s_nxt.aw_v = 1'b1;
            s_nxt.aw_a = awaddr;
        end
        if (wvalid && wready) begin
            s_nxt.w_v = 1'b1;
            s_nxt.w_d = wdata;
            s_nxt.w_s = wstrb;
        end
        if (s_r.b_v && bready) begin
            s_nxt.b_v = 1'b0;
        end
        if (s_r.aw_v && s_r.w_v) begin
            s_nxt.aw_v = 1'b0;
            s_nxt.w_v = 1'b0;
            s_nxt.b_v = 1'b1;
            idx = s_r.aw_a[INST_LSB +: INST_W];
            off = s_r.aw_a & ((ADDR_W'(1) << INST_LSB) - 1'b1);
            hit = 1'b1;
            if (s_r.aw_a < OFS_STATUS) begin
                case (off)
                    OFS_LIM_CFG: old = DATA_W'(s_r.cfg[idx].limc);
                    OFS_LIM_UL: old = s_r.cfg[idx].lim_ul;
                    OFS_LIM_LL: old = s_r.cfg[idx].lim_ll;
                    OFS_LIM_DLY: old = DATA_W'(s_r.cfg[idx].delay);
                    OFS_CAM_CFG: old = DATA_W'(s_r.cfg[idx].cam_en);
                    OFS_CAM_UL: old = s_r.cfg[idx].cam_ul;
                    OFS_CAM_LL: old = s_r.cfg[idx].cam_ll;
                    default: hit = 1'b0;
                endcase
                m = spw_merge(old, s_r.w_d, s_r.w_s);
                case (off)
                    OFS_LIM_CFG: s_nxt.cfg[idx].limc = spw_limc_t'(m[LIMC_W-1:0]);
                    OFS_LIM_UL: s_nxt.cfg[idx].lim_ul = m;
                    OFS_LIM_LL: s_nxt.cfg[idx].lim_ll = m;
                    OFS_LIM_DLY: s_nxt.cfg[idx].delay = m[DLY_W-1:0];
                    OFS_CAM_CFG: s_nxt.cfg[idx].cam_en = m[0];
                    OFS_CAM_UL: s_nxt.cfg[idx].cam_ul = m;
                    OFS_CAM_LL: s_nxt.cfg[idx].cam_ll = m;
                    default: ;
                endcase
            end else begin
                case (s_r.aw_a)
                    OFS_IRQ_MSK: begin
                        m = spw_merge(DATA_W'(s_r.irq_msk), s_r.w_d, s_r.w_s);
                        s_nxt.irq_msk = m[N_EV-1:0];
                    end
                    OFS_SDO_MAP: begin
                        m = spw_merge(DATA_W'(s_r.sdom), s_r.w_d, s_r.w_s);
                        s_nxt.sdom = spw_sdom_t'(m[SDOM_W-1:0]);
                    end
                    OFS_STATUS, OFS_IRQ_ST: ;
                    default: hit = 1'b0;
                endcase
            end
            s_nxt.b_r = hit ? RESP_OKAY : RESP_SLVERR;
        end

        // Read channel; the interrupt status clears on read
        if (s_r.r_v && rready) begin
            s_nxt.r_v = 1'b0;
        end
        if (arvalid && arready) begin
            s_nxt.r_v = 1'b1;
            idx = araddr[INST_LSB +: INST_W];
            off = araddr & ((ADDR_W'(1) << INST_LSB) - 1'b1);
            hit = 1'b1;
            s_nxt.r_d = '0;
            if (araddr < OFS_STATUS) begin
                case (off)
                    OFS_LIM_CFG: s_nxt.r_d = DATA_W'(s_r.cfg[idx].limc);
                    OFS_LIM_UL: s_nxt.r_d = s_r.cfg[idx].lim_ul;
                    OFS_LIM_LL: s_nxt.r_d = s_r.cfg[idx].lim_ll;
                    OFS_LIM_DLY: s_nxt.r_d = DATA_W'(s_r.cfg[idx].delay);
                    OFS_CAM_CFG: s_nxt.r_d = DATA_W'(s_r.cfg[idx].cam_en);
                    OFS_CAM_UL: s_nxt.r_d = s_r.cfg[idx].cam_ul;
                    OFS_CAM_LL: s_nxt.r_d = s_r.cfg[idx].cam_ll;
                    default: hit = 1'b0;
                endcase
            end else begin
                case (araddr)
                    OFS_STATUS: s_nxt.r_d = DATA_W'(ist);
                    OFS_IRQ_ST: begin
                        s_nxt.r_d = DATA_W'(s_r.irq_st);
                        s_nxt.irq_st = '0;
                    end
                    OFS_IRQ_MSK: s_nxt.r_d = DATA_W'(s_r.irq_msk);
                    OFS_SDO_MAP: s_nxt.r_d = DATA_W'(s_r.sdom);
                    default: hit = 1'b0;
                endcase
            end
            s_nxt.r_r = hit ? RESP_OKAY : RESP_SLVERR;
        end

        // Events: fault entry and cam window change; set wins over read-clear
        for (int i = 0; i < N_INST; i++) begin
            s_nxt.fail_d[i] = ist[i].fault;
            s_nxt.cam_d[i] = ist[i].cam_in;
            ev[i] = ist[i].fault && !s_r.fail_d[i];
            ev[N_INST + i] = ist[i].cam_in != s_r.cam_d[i];
        end
        s_nxt.irq_st = s_nxt.irq_st | ev;

        // Most severe reaction among failed instances
        s_nxt.fault_any = 1'b0;
        s_nxt.react = REACT_NONE;
        for (int i = 0; i < N_INST; i++) begin
            if (ist[i].fault) begin
                s_nxt.fault_any = 1'b1;
                if (s_nxt.react == REACT_NONE || ist[i].react < s_nxt.react) begin
                    s_nxt.react = ist[i].react;
                end
            end
        end

        // Safe output routing; an odd output follows its even partner when paired
        for (int k = 0; k < N_SDO; k++) begin
            src = ((k % 2) == 1 && s_r.sdom.pair[k/2]) ? s_r.sdom.sel[k-1] : s_r.sdom.sel[k];
            v = 1'b0;
            for (int i = 0; i < N_INST; i++) begin
                if (src == MAP_LIM0 + 3'(i)) begin
                    v = ist[i].lim_active;
                end
                if (src == MAP_CAM0 + 3'(i)) begin
                    v = ist[i].cam_in;
                end
            end
            s_nxt.sdo[k] = v;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
            s_r.cfg <= {N_INST{ICFG_RST}};
        end else begin
            s_r <= s_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign awready = !s_r.aw_v && !s_r.b_v;
    assign wready = !s_r.w_v && !s_r.b_v;
    assign bvalid = s_r.b_v;
    assign bresp = s_r.b_r;
    assign arready = !s_r.r_v;
    assign rvalid = s_r.r_v;
    assign rdata = s_r.r_d;
    assign rresp = s_r.r_r;
    assign fault_activate = s_r.fault_any;
    assign fault_reaction = s_r.react;
    assign test_pulsed_safe_output = s_r.sdo;
    assign irq = |(s_r.irq_st & s_r.irq_msk);
endmodule

//--- verif/spw_act_model.sv
`timescale 1ns/1ns
module spw_act_model (
    input wire logic aclk, // Clock
    input wire logic aresetn, // Reset
    input wire logic [spw_pkg::N_INST-1:0] fb_req, // Wanted fieldbus levels
    input wire logic [3:0] si_req, // Wanted input levels
    output logic [spw_pkg::N_INST-1:0] fieldbus_activate, // To block
    output logic [3:0] safe_input // To block
);
    import spw_pkg::*;
    // Levels move only on an edge, as a cyclic frame would deliver them
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fieldbus_activate <= '0;
            safe_input <= '0;
        end else begin
            fieldbus_activate <= fb_req;
            safe_input <= si_req;
        end
    end
endmodule

//--- verif/spw_monitor_sva.sv
`timescale 1ns/1ns
module spw_monitor_sva (
    input wire logic aclk, // in
    input wire logic aresetn, // in
    input wire logic awvalid, // in
    input wire logic awready, // in
    input wire logic wvalid, // in
    input wire logic wready, // in
    input wire logic bvalid, // in
    input wire logic bready, // in
    input wire logic arvalid, // in
    input wire logic arready, // in
    input wire logic rvalid, // in
    input wire logic rready, // in
    input wire logic [spw_pkg::N_INST-1:0] position_limit_active_status, // in
    input wire logic [2*spw_pkg::N_INST-1:0] position_limit_internal_state, // in
    input wire logic fault_activate, // in
    input wire logic [1:0] fault_reaction, // in
    input wire logic [spw_pkg::N_INST-1:0] cam_in_window_status, // in
    input wire logic [2*spw_pkg::N_INST-1:0] cam_internal_state // in
);
    import spw_pkg::*;
    logic [N_INST-1:0] st_nz;
    logic [N_INST-1:0] st_fail;
    logic [N_INST-1:0] cam_in;
    always_comb begin
        for (int i = 0; i < N_INST; i++) begin
            st_nz[i] = position_limit_internal_state[2*i+:2] != ST_INACTIVE;
            st_fail[i] = position_limit_internal_state[2*i+:2] == ST_FAILED;
            cam_in[i] = cam_internal_state[2*i+:2] == CAM_ST_IN;
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_aw_refused: assert property (bvalid |-> !awready && !wready)
        else $error("write taken during response");
    a_b_stands: assert property (bvalid && !bready |=> bvalid)
        else $error("write response dropped");
    a_r_stands: assert property (rvalid && !rready |=> rvalid)
        else $error("read data dropped");
    a_ar_refused: assert property (rvalid |-> !arready)
        else $error("read taken during data");
    a_read_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read not answered");
    a_write_answer: assert property (awvalid && awready && wvalid && wready |=> ##1 bvalid)
        else $error("write not answered");
    a_fault_follows: assert property (fault_activate == $past(|st_fail))
        else $error("fault request wrong");
    a_active_state: assert property (position_limit_active_status == st_nz)
        else $error("active status wrong");
    a_fail_sticky: assert property (st_fail[0] |=> position_limit_internal_state[1:0] != ST_ACTIVE)
        else $error("failed went back to active");
    a_cam_flag: assert property (cam_in_window_status == cam_in)
        else $error("cam flag wrong");
    a_react_idle: assert property (!fault_activate |-> fault_reaction == REACT_NONE)
        else $error("reaction without fault");
endmodule
bind spw_monitor spw_monitor_sva spw_monitor_sva_i (.*);

//--- verif/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    import spw_pkg::*;
    localparam int CPM = 5;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, fault_activate, irq;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [DATA_W-1:0] wdata, rdata, safe_position;
    logic [3:0] wstrb, safe_input, si_req, test_pulsed_safe_output;
    logic [1:0] bresp, rresp, fault_reaction;
    logic [N_INST-1:0] fieldbus_activate, fb_req, position_limit_active_status, cam_in_window_status;
    logic [2*N_INST-1:0] position_limit_internal_state, cam_internal_state;
    int mismatches, n_checks;
    spw_monitor #(.CYC_PER_MS(CPM)) spw_monitor_i (.*);
    spw_act_model spw_act_model_i (.*);
    always #50 aclk = ~aclk;
    // --------------------------------
    // Helpers
    // --------------------------------
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tmo(input logic ok);
        if (!ok) begin
            mismatches++;
            $display("Bus wait ran out at %0t", $time);
            end_sim;
        end
    endtask
    task automatic settle(input int k);
        repeat (k) @(negedge aclk);
    endtask
    // Handshakes judged at the falling edge, where inputs already stand for the next rise
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        logic ta, tw, tb;
        n = 0;
        tb = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!tb && n < 40) begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            if (tb) chk(bresp, er);
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            n++;
        end
        bready <= 1'b0;
        tmo(tb);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        logic ta, tr;
        n = 0;
        tr = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!tr && n < 40) begin
            @(negedge aclk);
            ta = arvalid && arready;
            tr = rvalid;
            if (tr) chk(rdata, ed);
            if (tr) chk(rresp, er);
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            n++;
        end
        rready <= 1'b0;
        tmo(tr);
    endtask
    // --------------------------------
    // Scenarios
    // --------------------------------
    task automatic t_reset;
        rd(OFS_LIM_CFG, 32'h10, RESP_OKAY);
        rd(OFS_LIM_DLY, 32'h0, RESP_OKAY);
        rd(OFS_CAM_UL, 32'h0, RESP_OKAY);
        rd(OFS_CAM_LL, 32'h0, RESP_OKAY);
        rd(8'h70, 32'h0, RESP_SLVERR);
        wr(8'h74, 32'h1, RESP_SLVERR);
        $display("test reset done");
    endtask
    task automatic t_lim;
        wr(OFS_LIM_UL, 32'd10, RESP_OKAY);
        wr(OFS_LIM_LL, 32'hffff_fff6, RESP_OKAY);
        wr(OFS_IRQ_MSK, 32'h1, RESP_OKAY);
        wr(OFS_LIM_CFG, 32'h11, RESP_OKAY);
        safe_position <= 32'd10;
        fb_req <= 3'h1;
        settle(6);
        chk(position_limit_internal_state, 6'h1);
        @(posedge aclk);
        safe_position <= 32'hffff_fff6;
        settle(4);
        chk(fault_activate, 1'b0);
        @(posedge aclk);
        safe_position <= 32'd11;
        settle(4);
        chk(position_limit_internal_state, 6'h2);
        chk(position_limit_active_status, 3'h1);
        chk(fault_activate, 1'b1);
        chk(fault_reaction, REACT_TOF);
        chk(irq, 1'b1);
        rd(OFS_IRQ_ST, 32'h1, RESP_OKAY);
        settle(2);
        chk(irq, 1'b0);
        @(posedge aclk);
        fb_req <= 3'h0;
        settle(4);
        chk(position_limit_internal_state, 6'h0);
        chk(fault_activate, 1'b0);
        $display("test lim done");
    endtask
    task automatic t_react;
        for (int r = 1; r < 4; r++) begin
            wr(8'h20, {26'h0, r[1:0], 4'h6}, RESP_OKAY);
            si_req <= 4'h1;
            settle(6);
            chk(position_limit_active_status, 3'h0);
            @(posedge aclk);
            si_req <= 4'h2;
            settle(6);
            chk(position_limit_internal_state, 6'h8);
            chk(fault_reaction, r[1:0]);
            chk(irq, 1'b0);
            @(posedge aclk);
            si_req <= 4'h0;
            settle(4);
        end
        $display("test react done");
    endtask
    task automatic t_delay;
        wr(8'h4c, 32'h2, RESP_OKAY);
        wr(8'h40, 32'h11, RESP_OKAY);
        fb_req <= 3'h4;
        settle(8);
        chk(position_limit_internal_state, 6'h10);
        settle(14);
        chk(position_limit_internal_state, 6'h20);
        @(posedge aclk);
        fb_req <= 3'h0;
        settle(4);
        $display("test delay done");
    endtask
    task automatic t_cam;
        wr(OFS_CAM_UL, 32'd20, RESP_OKAY);
        wr(OFS_CAM_CFG, 32'h1, RESP_OKAY);
        wr(8'h50, 32'h1, RESP_OKAY);
        wr(OFS_SDO_MAP, 32'h1121, RESP_OKAY);
        safe_position <= 32'd20;
        settle(4);
        chk(cam_in_window_status, 3'h1);
        chk(cam_internal_state, 6'h21);
        chk(test_pulsed_safe_output, 4'h4);
        @(posedge aclk);
        safe_position <= 32'd21;
        settle(4);
        chk(cam_internal_state, 6'h22);
        chk(test_pulsed_safe_output, 4'h0);
        @(posedge aclk);
        safe_position <= 32'd0;
        fb_req <= 3'h1;
        settle(6);
        chk(cam_in_window_status, 3'h5);
        chk(test_pulsed_safe_output, 4'h7);
        $display("test cam done");
    endtask
    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, safe_position} = '0;
        wstrb = 4'hf;
        fb_req = '0;
        si_req = '0;
        mismatches = 0;
        n_checks = 0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        t_lim;
        t_react;
        t_delay;
        t_cam;
        end_sim;
    end
endmodule
